// ---- inc/alu_decoder_consts.vh ----
/*
 Constants for the logic/compare/word ALU instruction decoder: opcode
 patterns, field positions, operation codes and sequencer states.
 Assumes inclusion by bare name from the design file.
*/
`ifndef ALU_DECODER_CONSTS_VH
`define ALU_DECODER_CONSTS_VH
// Prefix byte for special-register and alternate forms
`define PREFIX_BYTE      8'h01
// Upper five-bit form selectors
`define HI_IMM_ACC       5'h15
`define HI_SADDR_IMM     5'h0d
`define HI_REG_REG       5'h11
`define HI_ACC_SADDR     5'h13
`define HI_SADDR_SADDR   5'h0f
`define HI_WORD_IMM      5'h05
`define HI_WORD_SFR      5'h03
// Memory form: top three zero bits, op field flag
`define MEM_TOP          3'h0
`define MEM_OP_FLAG      1'b1
// Word operation codes (low three bits)
`define WOP_ADD          3'h5
`define WOP_SUB          3'h6
`define WOP_CMP          3'h7
// Three-bit operation codes
`define OP_ADD           3'h0
`define OP_ADDC          3'h1
`define OP_SUB           3'h2
`define OP_SUBC          3'h3
`define OP_AND           3'h4
`define OP_XOR           3'h5
`define OP_OR            3'h6
`define OP_CMP           3'h7
// ALU select codes (bit 3 marks word width)
`define ALU_WADD         4'h8
`define ALU_WSUB         4'h9
`define ALU_WCMP         4'ha
// Operand form codes
`define FORM_ACC_IMM     4'h0
`define FORM_SADDR_IMM   4'h1
`define FORM_SFR_IMM     4'h2
`define FORM_REG_REG     4'h3
`define FORM_ACC_SADDR   4'h4
`define FORM_ACC_SFR     4'h5
`define FORM_SADDR_SADDR 4'h6
`define FORM_ACC_MEM     4'h7
`define FORM_ACC_AMEM    4'h8
`define FORM_WORD_IMM    4'h9
`define FORM_WORD_SFR    4'ha
// Sequencer states
`define ST_FIRST         3'h0
`define ST_SECOND        3'h1
`define ST_OPER1         3'h2
`define ST_OPER2         3'h3
`define ST_MEM2          3'h4
`endif

// ---- hdl/logic_compare_word_alu_decoder.v ----
/*
 Decoder for the byte logic/compare group and the word add/subtract/
 compare group. Takes one fetched byte per fetch_valid cycle, collects
 operand bytes, and pulses alu_start with all fields when complete.
 Assumes the fetch stream is synchronous to clk and starts aligned to
 an instruction boundary after reset.
*/
`timescale 1ns/10ps
`include "alu_decoder_consts.vh"
module logic_compare_word_alu_decoder
(
   // Clock and reset
   input  wire       clk,
   input  wire       rst_n,
   // Fetch stream
   input  wire       fetch_valid,
   input  wire [7:0] fetch_byte,
   // Decoded operation
   output reg        alu_start,
   output reg  [3:0] alu_op,
   output reg  [3:0] operand_form,
   output reg        write_result,
   output reg        word_op,
   output reg  [7:0] operand_a,
   output reg  [7:0] operand_b,
   output reg  [2:0] dst_sel,
   output reg  [2:0] src_sel,
   output reg  [2:0] mem_mode,
   output reg  [2:0] mem_ptr,
   output reg        alt_memory,
   output reg        undefined_insn
);
   // Sequencer state and collected context
   reg [2:0] state_reg,  state_next;     // Byte position
   reg [3:0] form_reg,   form_next;      // Form being collected
   reg [3:0] op_reg,     op_next;        // ALU select held
   reg       pre_reg,    pre_next;       // Prefix seen
   reg [7:0] a_reg,      a_next;         // First operand byte
   reg [2:0] mode_reg,   mode_next;      // Memory mode field
   reg [2:0] ptr_reg,    ptr_next;       // Memory pointer field
   reg       done;                       // Instruction complete
   reg       bad;                        // Undefined encoding
   reg [7:0] b_val;                      // Final operand byte
   reg [2:0] dsel;                       // Register destination
   reg [2:0] ssel;                       // Register source
   wire [4:0] hi = fetch_byte[7:3];      // Form selector bits
   wire [2:0] lo = fetch_byte[2:0];      // Operation bits

   // Next-state decode of each incoming byte
   always @*
   begin
      state_next = state_reg;
      form_next  = form_reg;
      op_next    = op_reg;
      pre_next   = pre_reg;
      a_next     = a_reg;
      mode_next  = mode_reg;
      ptr_next   = ptr_reg;
      done       = 1'b0;
      bad        = 1'b0;
      b_val      = 8'h00;
      dsel       = 3'h0;
      ssel       = 3'h0;
      if (fetch_valid)
      begin
         case (state_reg)
            `ST_FIRST:
            begin
               op_next = {1'b0, lo};
               pre_next = 1'b0;
               state_next = `ST_OPER1;
               if (fetch_byte == `PREFIX_BYTE)
               begin
                  pre_next   = 1'b1;
                  state_next = `ST_SECOND;
               end
               else if (hi == `HI_IMM_ACC)
                  // Whole immediate group, add codes included
                  form_next = `FORM_ACC_IMM;
               else if (hi == `HI_SADDR_IMM)
                  form_next = `FORM_SADDR_IMM;
               else if (hi == `HI_REG_REG)
                  form_next = `FORM_REG_REG;
               else if (hi == `HI_ACC_SADDR)
                  form_next = `FORM_ACC_SADDR;
               else if (hi == `HI_SADDR_SADDR)
                  form_next = `FORM_SADDR_SADDR;
               else if (hi == `HI_WORD_IMM && lo >= `WOP_ADD)
               begin
                  form_next = `FORM_WORD_IMM;
                  op_next   = `ALU_WADD + {1'b0, lo - `WOP_ADD};
               end
               else if (fetch_byte[7:5] == `MEM_TOP)
               begin
                  form_next  = `FORM_ACC_MEM;
                  mode_next  = fetch_byte[4:2];
                  ptr_next   = {fetch_byte[1:0], 1'b0};
                  state_next = `ST_SECOND;
               end
               else
               begin
                  bad        = 1'b1;
                  state_next = `ST_FIRST;
               end
            end
            `ST_SECOND:
            begin
               state_next = `ST_OPER1;
               op_next    = {1'b0, lo};
               if (!pre_reg)
               begin
                  // Memory form tail: pointer low bit, flag, op
                  ptr_next = {ptr_reg[2:1], fetch_byte[7]};
                  if (fetch_byte[6:4] != 3'h0 || fetch_byte[3] != `MEM_OP_FLAG)
                  begin
                     bad = 1'b1;
                     state_next = `ST_FIRST;
                  end
               end
               else if (hi == `HI_SADDR_IMM)
                  form_next = `FORM_SFR_IMM;
               else if (hi == `HI_ACC_SADDR)
                  form_next = `FORM_ACC_SFR;
               else if (hi == `HI_WORD_SFR && lo >= `WOP_ADD)
               begin
                  form_next = `FORM_WORD_SFR;
                  op_next   = `ALU_WADD + {1'b0, lo - `WOP_ADD};
               end
               else if (fetch_byte[7:5] == `MEM_TOP)
               begin
                  form_next  = `FORM_ACC_AMEM;
                  mode_next  = fetch_byte[4:2];
                  ptr_next   = {fetch_byte[1:0], 1'b0};
                  pre_next   = 1'b0;
                  state_next = `ST_SECOND;
               end
               else
               begin
                  bad = 1'b1;
                  state_next = `ST_FIRST;
               end
            end
            `ST_OPER1:
            begin
               a_next = fetch_byte;
               b_val  = fetch_byte;
               case (form_reg)
                  `FORM_REG_REG:
                  begin
                     dsel = fetch_byte[6:4];
                     ssel = fetch_byte[2:0];
                     if (fetch_byte[7] | fetch_byte[3])
                        bad = 1'b1;
                     else
                        done = 1'b1;
                     state_next = `ST_FIRST;
                  end
                  `FORM_ACC_IMM, `FORM_ACC_SADDR, `FORM_ACC_SFR, `FORM_WORD_SFR:
                  begin
                     done = 1'b1;
                     state_next = `ST_FIRST;
                  end
                  default:
                     state_next = `ST_OPER2;
               endcase
            end
            `ST_OPER2:
            begin
               b_val = fetch_byte;
               done  = 1'b1;
               state_next = `ST_FIRST;
            end
            default:
               state_next = `ST_FIRST;
         endcase
      end
   end

   // Registered state and outputs
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg      <= `ST_FIRST;
         form_reg       <= 4'h0;
         op_reg         <= 4'h0;
         pre_reg        <= 1'b0;
         a_reg          <= 8'h00;
         mode_reg       <= 3'h0;
         ptr_reg        <= 3'h0;
         alu_start      <= 1'b0;
         alu_op         <= 4'h0;
         operand_form   <= 4'h0;
         write_result   <= 1'b0;
         word_op        <= 1'b0;
         operand_a      <= 8'h00;
         operand_b      <= 8'h00;
         dst_sel        <= 3'h0;
         src_sel        <= 3'h0;
         mem_mode       <= 3'h0;
         mem_ptr        <= 3'h0;
         alt_memory     <= 1'b0;
         undefined_insn <= 1'b0;
      end
      else
      begin
         state_reg      <= state_next;
         form_reg       <= form_next;
         op_reg         <= op_next;
         pre_reg        <= pre_next;
         a_reg          <= a_next;
         mode_reg       <= mode_next;
         ptr_reg        <= ptr_next;
         alu_start      <= done;
         undefined_insn <= bad;
         if (done)
         begin
            alu_op       <= op_reg;
            operand_form <= form_reg;
            word_op      <= op_reg[3];
            // Compares leave destination unchanged
            write_result <= (op_reg != {1'b0, `OP_CMP}) && (op_reg != `ALU_WCMP);
            operand_a    <= (state_reg == `ST_OPER2) ? a_reg : fetch_byte;
            operand_b    <= (state_reg == `ST_OPER2) ? b_val : 8'h00;
            dst_sel      <= dsel;
            src_sel      <= ssel;
            mem_mode     <= mode_reg;
            mem_ptr      <= ptr_reg;
            alt_memory   <= (form_reg == `FORM_ACC_AMEM);
         end
      end
   end
endmodule // logic_compare_word_alu_decoder

// ---- testbench/alu_decoder_checker.sv ----
/* Checker of the decoder's output relations.
   Bound to the decoder top; sees its ports only. */
`timescale 1ns/10ps
module alu_decoder_checker
(
   // Clock and reset
   input wire logic       clk,
   input wire logic       rst_n,
   // Fetch and results
   input wire logic       fetch_valid,
   input wire logic       alu_start,
   input wire logic [3:0] alu_op,
   input wire logic [3:0] operand_form,
   input wire logic       write_result,
   input wire logic       word_op,
   input wire logic [7:0] operand_a,
   input wire logic [2:0] dst_sel,
   input wire logic [2:0] src_sel,
   input wire logic       undefined_insn
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Two cycles with no completion
   sequence quiet_s;
      !alu_start ##1 !alu_start;
   endsequence
   one_answer_a: assert property (alu_start |-> !undefined_insn) else $error("start with undefined");
   undef_quiet_a: assert property (undefined_insn |-> quiet_s) else $error("start after undefined");
   byte_taken_a: assert property (alu_start || undefined_insn |-> $past(fetch_valid)) else $error("no last byte");
   cmp_keep_a: assert property (alu_start && alu_op inside {4'h7, 4'ha} |-> !write_result)
      else $error("compare writes");
   logic_write_a: assert property (alu_start && alu_op inside {4'h4, 4'h5, 4'h6} |-> write_result)
      else $error("logic op not written");
   word_flag_a: assert property (alu_start |-> word_op == alu_op[3]) else $error("word flag wrong");
   reg_sel_a: assert property (alu_start && operand_form == 4'h3 |-> {dst_sel, src_sel} ==
      {operand_a[6:4], operand_a[2:0]}) else $error("selectors wrong");
   sel_zero_a: assert property (alu_start && operand_form != 4'h3 |-> {dst_sel, src_sel} == 6'h00)
      else $error("selectors not clear");
   fields_hold_a: assert property (!alu_start |-> $stable(alu_op) && $stable(operand_a))
      else $error("fields moved");
endmodule // alu_decoder_checker
bind logic_compare_word_alu_decoder alu_decoder_checker i_alu_decoder_checker
   (.clk(clk), .rst_n(rst_n), .fetch_valid(fetch_valid), .alu_start(alu_start), .alu_op(alu_op),
    .operand_form(operand_form), .write_result(write_result), .word_op(word_op), .operand_a(operand_a),
    .dst_sel(dst_sel), .src_sel(src_sel), .undefined_insn(undefined_insn));

// ---- testbench/fetch_source.sv ----
/* Program fetch model: hands queued bytes over, one per cycle.
   Assumes the bench fills q and may set gap for a slow fetch. */
`timescale 1ns/10ps
module fetch_source
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Fetch stream
   output      logic       fetch_valid,
   output      logic [7:0] fetch_byte
);
   logic [7:0] q[$];      // Pending bytes
   int         gap  = 0;  // Idle cycles after each byte
   int         idle = 0;  // Idle cycles left
   // One process drives the stream; idle lines toggle so stale data never looks valid
   initial
   begin
      fetch_valid = 1'b0;
      fetch_byte  = 8'h00;
      forever
      begin
         @(posedge clk);
         #1;
         if (rst_n && q.size() > 0 && idle == 0)
         begin
            fetch_valid = 1'b1;
            fetch_byte  = q.pop_front();
            idle        = gap;
         end
         else
         begin
            idle        = (idle > 0) ? idle - 1 : 0;
            fetch_valid = 1'b0;
            fetch_byte  = ~fetch_byte;
         end
      end
   end
endmodule // fetch_source

// ---- testbench/logic_compare_word_alu_decoder_tb.sv ----
/* Self-checking bench for the decoder.
   Assumes the fetch model drives the stream. */
`timescale 1ns/10ps
module logic_compare_word_alu_decoder_tb;
   logic       clk, rst_n, fetch_valid, alu_start, write_result, word_op, alt_memory, undefined_insn;
   logic [7:0] fetch_byte, operand_a, operand_b;
   logic [3:0] alu_op, operand_form;
   logic [2:0] dst_sel, src_sel, mem_mode, mem_ptr;
   int         fails = 0;        // Mismatches
   int         comparisons = 0;  // Checks made
   int         cycles = 0;       // Run length
   fetch_source i_fetch_source (.clk(clk), .rst_n(rst_n), .fetch_valid(fetch_valid), .fetch_byte(fetch_byte));
   logic_compare_word_alu_decoder i_logic_compare_word_alu_decoder
      (.clk(clk), .rst_n(rst_n), .fetch_valid(fetch_valid), .fetch_byte(fetch_byte), .alu_start(alu_start),
       .alu_op(alu_op), .operand_form(operand_form), .write_result(write_result), .word_op(word_op),
       .operand_a(operand_a), .operand_b(operand_b), .dst_sel(dst_sel), .src_sel(src_sel),
       .mem_mode(mem_mode), .mem_ptr(mem_ptr), .alt_memory(alt_memory), .undefined_insn(undefined_insn));
   // Compare one value
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Verdict and end of run
   task finish_test();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Queue bytes at the fetch model
   task send(input logic [7:0] b[$]);
      foreach (b[i])
         i_fetch_source.q.push_back(b[i]);
   endtask
   // Wait for either pulse, bounded
   task wait_ans();
      int n;
      n = 0;
      do
      begin
         @(posedge clk);
         #2;
         n++;
      end
      while (alu_start !== 1'b1 && undefined_insn !== 1'b1 && n < 40);
   endtask
   // Check one completed operation
   task exp_op(input logic [3:0] op, input logic [3:0] form, input logic [7:0] a, b, input logic wr);
      wait_ans();
      chk(alu_start, 8'h01);
      chk({alu_op, operand_form}, {op, form});
      chk(operand_a, a);
      chk(operand_b, b);
      chk({word_op, write_result}, {op[3], wr});
   endtask
   // All eight immediate byte ops, back to back
   task t_imm();
      logic [7:0] k;
      for (k = 8'h00; k < 8'h08; k++)
         send('{8'ha8 | k, k ^ 8'h5a});
      for (k = 8'h00; k < 8'h08; k++)
         exp_op(k[3:0], 4'h0, k ^ 8'h5a, 8'h00, k != 8'h07);
   endtask
   // Operand forms with a slow fetch
   task t_forms();
      i_fetch_source.gap = 1;
      send('{8'h6c, 8'h11, 8'h22, 8'h01, 8'h6e, 8'h33, 8'h44, 8'h8d, 8'h53, 8'h9f, 8'h66});
      send('{8'h7c, 8'h12, 8'h34, 8'h01, 8'h9e, 8'h77});
      exp_op(4'h4, 4'h1, 8'h11, 8'h22, 1'b1);
      exp_op(4'h6, 4'h2, 8'h33, 8'h44, 1'b1);
      exp_op(4'h5, 4'h3, 8'h53, 8'h00, 1'b1);
      chk({dst_sel, src_sel}, 8'h2b);
      exp_op(4'h7, 4'h4, 8'h66, 8'h00, 1'b0);
      exp_op(4'h4, 4'h6, 8'h12, 8'h34, 1'b1);
      exp_op(4'h6, 4'h5, 8'h77, 8'h00, 1'b1);
      i_fetch_source.gap = 0;
   endtask
   // Memory forms, plain and prefixed
   task t_mem();
      send('{8'h0a, 8'h8c, 8'h10, 8'h20, 8'h01, 8'h0a, 8'h8f, 8'h30, 8'h40});
      exp_op(4'h4, 4'h7, 8'h10, 8'h20, 1'b1);
      chk({alt_memory, mem_mode, mem_ptr}, 8'h15);
      exp_op(4'h7, 4'h8, 8'h30, 8'h40, 1'b0);
      chk({alt_memory, mem_mode, mem_ptr}, 8'h55);
   endtask
   // Word immediate and prefixed special-register forms
   task t_word();
      send('{8'h2d, 8'h34, 8'h12, 8'h2e, 8'h78, 8'h56, 8'h2f, 8'hcd, 8'hab, 8'h01, 8'h1d, 8'h55});
      exp_op(4'h8, 4'h9, 8'h34, 8'h12, 1'b1);
      exp_op(4'h9, 4'h9, 8'h78, 8'h56, 1'b1);
      exp_op(4'ha, 4'h9, 8'hcd, 8'hab, 1'b0);
      exp_op(4'h8, 4'ha, 8'h55, 8'h00, 1'b1);
   endtask
   // Rejected bytes, then recovery
   task t_undef();
      send('{8'hff, 8'hac, 8'h01, 8'h01, 8'hff, 8'h8c, 8'h88});
      wait_ans();
      chk({undefined_insn, alu_start}, 8'h02);
      exp_op(4'h4, 4'h0, 8'h01, 8'h00, 1'b1);
      wait_ans();
      chk({undefined_insn, alu_start}, 8'h02);
      wait_ans();
      chk({undefined_insn, alu_start}, 8'h02);
   endtask
   // Reset in mid-instruction clears outputs and realigns decode
   task t_reset();
      send('{8'h6c, 8'h99});
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b0;
      #2;
      chk({alu_start, undefined_insn, write_result, word_op, alt_memory, 3'h0}, 8'h00);
      chk({alu_op, operand_form}, 8'h00);
      chk(operand_a, 8'h00);
      chk(operand_b, 8'h00);
      chk({2'h0, dst_sel, src_sel}, 8'h00);
      chk({2'h0, mem_mode, mem_ptr}, 8'h00);
      repeat (3) @(posedge clk);
      #1 rst_n = 1'b1;
      send('{8'hac, 8'h3c});
      exp_op(4'h4, 4'h0, 8'h3c, 8'h00, 1'b1);
   endtask
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 2000)
      begin
         fails++;
         finish_test();
      end
   end
   initial
   begin
      rst_n = 1'b0;
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
      t_imm();
      t_forms();
      t_mem();
      t_word();
      t_undef();
      t_reset();
      finish_test();
   end
endmodule // logic_compare_word_alu_decoder_tb
